// >>> pkg/clkgen_pkg.sv
// How it works
// R1: software sets the amplitude range bit once, before main clock mode setup.
// R2: crystal as cpu source and amplitude bit set: cpu clock held 5.00-19.35 us.
// R3: external clock as cpu source and amplitude bit set: hold 160 external clocks.
// R4: stop release with amplitude bit: hold by time, external clocks or oscillator wait.
// R5: pin-select bits change only while the high-speed oscillator halt bit is one.
// R6: software writes zeros to bits 1 to 5 of the oscillator mode register.
// R7: software never sets pll enable and amplitude range together.
// R8: for pll use, clear pll enable, enter stop, then set it again.
// R9: cpu clock is main clock divided by 1,2,4,8,16; divide-by-2 after reset.
// R10: software writes zeros to bits 3 to 7 of the cpu divider register.
// R11: the divider slows only the cpu clock, never the peripheral clock.
// R12: pll control reads 00h after reset and 80h once internal oscillator is stable.
// R13: stable status and pll mode status bits are read-only; writes ignored.
// R14: setting pll enable starts the pll and a 10 us settling wait; clearing stops it.
// R15: software uses the pll only with a 4 MHz reference.
// R16: mode switch within one old clock going to pll, within three leaving it.
// R17: peripheral clock is main clock, or the pll output when pll mode selected.
// R18: writing one to an oscillator halt bit stops it; zero keeps it running.
// R19: software checks main clock status before halting the internal oscillator.
// R20: main oscillator control resets to 80h; halt bit stops crystal or external input.
// R21: software clears the oscillator halt bit only in legal regulator and pin modes.
// R22: software checks main clock status before halting the high-speed oscillator.
// R23: read-only main clock status: 0 internal oscillator, 1 high-speed system clock.
package clkgen_pkg;
  // register word indices; byte address is four times the index
  localparam logic [15:0] OSC_MODE_IDX = 16'hff9f;
  localparam logic [15:0] OSC_PLL_IDX = 16'hffa0;
  localparam logic [15:0] CLK_STATUS_IDX = 16'hffa1;
  localparam logic [15:0] MAIN_OSC_IDX = 16'hffa2;
  localparam logic [15:0] CPU_DIV_IDX = 16'hfffb;
  // oscillator mode control fields
  localparam int EXT_SEL_BIT = 7;
  localparam int OSC_PIN_BIT = 6;
  localparam int AMP_BIT = 0;
  // pll control fields, then the clock status and main oscillator control fields
  localparam int IRC_STABLE_BIT = 7;
  localparam int PLL_ACTIVE_BIT = 5;
  localparam int PLL_POWER_BIT = 4;
  localparam int PLL_MODE_BIT = 3;
  localparam int LS_HALT_BIT = 1;
  localparam int HS_IRC_HALT_BIT = 0;
  localparam int CLK_STATUS_BIT = 1;
  localparam int HS_OSC_HALT_BIT = 7;
  // reset values and the largest legal divider code
  localparam logic [7:0] OSC_MODE_RST = 8'h00;
  localparam logic [7:0] MAIN_OSC_RST = 8'h80;
  localparam logic [2:0] CPU_DIV_RST = 3'h1;
  localparam logic [2:0] CPU_DIV_MAX = 3'h4;
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int STALL_MIN_NS = 5000;
  localparam int STALL_MAX_NS = 19350;
  localparam int PLL_WAIT_NS = 10000;
  localparam int STALL_CYC = (STALL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STALL_MAX_CYC = STALL_MAX_NS / CLK_PERIOD_NS;
  localparam int PLL_WAIT_CYC = (PLL_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXT_STALL_CLKS = 160;
  localparam int PLL_OFF_CYC = 3;
  localparam logic [8:0] STALL_LOAD = 9'(STALL_CYC);
  localparam logic [8:0] PLL_WAIT_LOAD = 9'(PLL_WAIT_CYC);
  localparam logic [8:0] EXT_STALL_LOAD = 9'(EXT_STALL_CLKS);
  localparam logic [1:0] PLL_OFF_LAST = 2'(PLL_OFF_CYC - 1);

  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_TIME = 4'h2,
    ST_EXT = 4'h4,
    ST_OST = 4'h8
  } stall_state_t;
endpackage : clkgen_pkg

// >>> pkg/timer_if.sv
`timescale 1ns/1ps
interface timer_if #(parameter int W = 9);
  logic start;
  logic tick;
  logic [W-1:0] load;
  logic busy;
  modport ctl (output start, output tick, output load, input busy);
  modport tmr (input start, input tick, input load, output busy);
endinterface : timer_if

// >>> rtl/cycle_timer.sv
`timescale 1ns/1ps
module cycle_timer #(
  parameter int W = 9
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  timer_if.tmr tif
);
  logic [W-1:0] cnt_q;

  // counts down one per tick; start reloads even while busy
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= '0;
    end else if (tif.start) begin
      cnt_q <= tif.load;
    end else if (tif.tick && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign tif.busy = (cnt_q != '0);
endmodule : cycle_timer

// >>> rtl/cpu_clk_div.sv
`timescale 1ns/1ps
module cpu_clk_div #(
  parameter int DW = 4
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [2:0] div_sel_in,
  output logic en_out
);
  logic [DW-1:0] cnt_q;
  logic [DW-1:0] mask;

  // one pulse every 2**div_sel cycles
  assign mask = ~({DW{1'b1}} << div_sel_in);
  assign en_out = ((cnt_q & mask) == mask);

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule : cpu_clk_div

// >>> rtl/clock_source_divider_pll_control.sv
`timescale 1ns/1ps
module clock_source_divider_pll_control (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [17:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic main_clk_source_status_in,
  input wire logic irc_ready_in,
  input wire logic ext_clk_in,
  input wire logic stop_release_in,
  input wire logic ost_done_in,
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic cpu_stalled_out,
  output logic osc_amp_high_range_out,
  output logic x1_osc_enable_out,
  output logic ext_clk_enable_out,
  output logic irc_osc_enable_out,
  output logic lowspeed_osc_enable_out,
  output logic pll_power_out,
  output logic pll_ready_out,
  output logic periph_pll_sel_out
);
  logic ext_clk_input_sel_q;
  logic osc_pin_sel_q;
  logic osc_amp_high_range_q;
  logic pll_power_enable_q;
  logic pll_mode_select_q;
  logic lowspeed_osc_halt_q;
  logic highspeed_irc_halt_q;
  logic hs_osc_halt_q;
  logic irc_stable_status_q;
  logic pll_active_status_q;
  logic [1:0] off_cnt_q;
  logic [2:0] div_sel_q;
  logic ack_q;
  logic [7:0] dat_q;
  logic ext_prev_q;
  clkgen_pkg::stall_state_t state_q;
  clkgen_pkg::stall_state_t state_d;

  timer_if #(.W(9)) time_tif ();
  timer_if #(.W(9)) ext_tif ();
  timer_if #(.W(9)) pll_tif ();

  // bus decode
  wire wb_req = wb_cyc_in && wb_stb_in;
  wire [15:0] word_idx = wb_adr_in[17:2];
  wire hit_mode = (word_idx == clkgen_pkg::OSC_MODE_IDX);
  wire hit_pll = (word_idx == clkgen_pkg::OSC_PLL_IDX);
  wire hit_stat = (word_idx == clkgen_pkg::CLK_STATUS_IDX);
  wire hit_mosc = (word_idx == clkgen_pkg::MAIN_OSC_IDX);
  wire hit_div = (word_idx == clkgen_pkg::CPU_DIV_IDX);
  wire wr_fire = wb_req && wb_we_in && ack_q && wb_sel_in[0];
  wire wr_mode = wr_fire && hit_mode;
  wire wr_pll = wr_fire && hit_pll;
  wire wr_mosc = wr_fire && hit_mosc;
  wire wr_div = wr_fire && hit_div;
  wire [7:0] wd = wb_dat_in[7:0];

  wire [7:0] mode_rd = {ext_clk_input_sel_q, osc_pin_sel_q, 5'h00, osc_amp_high_range_q};
  wire [7:0] pll_rd = {irc_stable_status_q, 1'b0, pll_active_status_q, pll_power_enable_q,
                       pll_mode_select_q, 1'b0, lowspeed_osc_halt_q, highspeed_irc_halt_q};
  wire [7:0] stat_rd = {6'h00, main_clk_source_status_in, 1'b0}; // R23
  wire [7:0] mosc_rd = {hs_osc_halt_q, 7'h00};
  wire [7:0] div_rd = {5'h00, div_sel_q};
  wire [7:0] rd_byte = hit_mode ? mode_rd :
                       hit_pll ? pll_rd :
                       hit_stat ? stat_rd :
                       hit_mosc ? mosc_rd :
                       hit_div ? div_rd : 8'h00;

  // one wait state: ack in the cycle after the request, dropped after one cycle
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_q <= 1'b0;
      dat_q <= 8'h00;
    end else begin
      ack_q <= wb_req && !ack_q;
      dat_q <= rd_byte;
    end
  end
  assign wb_ack_out = ack_q;
  assign wb_dat_out = {24'h00_0000, dat_q};

  // oscillator mode source selection
  wire ext_mode = ext_clk_input_sel_q && osc_pin_sel_q;
  wire x1_mode = !ext_clk_input_sel_q && osc_pin_sel_q;
  wire pin_sel_ok = hs_osc_halt_q; // R5
  wire amp_rise = wr_mode && wd[clkgen_pkg::AMP_BIT] && !osc_amp_high_range_q;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_clk_input_sel_q <= clkgen_pkg::OSC_MODE_RST[clkgen_pkg::EXT_SEL_BIT];
      osc_pin_sel_q <= clkgen_pkg::OSC_MODE_RST[clkgen_pkg::OSC_PIN_BIT];
      osc_amp_high_range_q <= clkgen_pkg::OSC_MODE_RST[clkgen_pkg::AMP_BIT];
    end else if (wr_mode) begin
      if (pin_sel_ok) begin
        ext_clk_input_sel_q <= wd[clkgen_pkg::EXT_SEL_BIT]; // R5
        osc_pin_sel_q <= wd[clkgen_pkg::OSC_PIN_BIT];
      end
      // amplitude bit sticks once set until reset
      osc_amp_high_range_q <= osc_amp_high_range_q | wd[clkgen_pkg::AMP_BIT]; // R1
    end
  end

  // pll control; status bits take no write data
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pll_power_enable_q <= 1'b0;
      pll_mode_select_q <= 1'b0;
      lowspeed_osc_halt_q <= 1'b0;
      highspeed_irc_halt_q <= 1'b0;
    end else if (wr_pll) begin // R13
      pll_power_enable_q <= wd[clkgen_pkg::PLL_POWER_BIT]; // R14
      pll_mode_select_q <= wd[clkgen_pkg::PLL_MODE_BIT];
      lowspeed_osc_halt_q <= wd[clkgen_pkg::LS_HALT_BIT]; // R18
      highspeed_irc_halt_q <= wd[clkgen_pkg::HS_IRC_HALT_BIT]; // R18
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irc_stable_status_q <= 1'b0;
      hs_osc_halt_q <= clkgen_pkg::MAIN_OSC_RST[clkgen_pkg::HS_OSC_HALT_BIT]; // R20
      div_sel_q <= clkgen_pkg::CPU_DIV_RST; // R9
      ext_prev_q <= 1'b0;
    end else begin
      irc_stable_status_q <= irc_stable_status_q | irc_ready_in; // R12
      ext_prev_q <= ext_clk_in;
      if (wr_mosc) begin
        hs_osc_halt_q <= wd[clkgen_pkg::HS_OSC_HALT_BIT];
      end
      // prohibited divider codes are dropped
      if (wr_div && wd[2:0] <= clkgen_pkg::CPU_DIV_MAX) begin
        div_sel_q <= wd[2:0]; // R9
      end
    end
  end

  // pll start and settling wait
  wire pll_start = wr_pll && wd[clkgen_pkg::PLL_POWER_BIT] && !pll_power_enable_q;
  assign pll_tif.start = pll_start; // R14
  assign pll_tif.tick = 1'b1;
  assign pll_tif.load = clkgen_pkg::PLL_WAIT_LOAD;
  wire pll_ready = pll_power_enable_q && !pll_tif.busy;

  cycle_timer #(.W(9)) pll_timer (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .tif(pll_tif)
  );

  // mode switch: one cycle going in, three cycles leaving
  wire go_pll = pll_mode_select_q && pll_ready && !pll_active_status_q;
  wire leave_pll = !pll_mode_select_q && pll_active_status_q;
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pll_active_status_q <= 1'b0;
      off_cnt_q <= 2'h0;
    end else begin
      if (!pll_power_enable_q) begin
        pll_active_status_q <= 1'b0;
      end else if (go_pll) begin
        pll_active_status_q <= 1'b1; // R16
      end else if (leave_pll && off_cnt_q == clkgen_pkg::PLL_OFF_LAST) begin
        pll_active_status_q <= 1'b0; // R16
      end
      off_cnt_q <= leave_pll ? off_cnt_q + 2'h1 : 2'h0;
    end
  end

  // cpu clock stall sequencer
  wire ext_rise = ext_clk_in && !ext_prev_q;
  wire on_hs_clk = main_clk_source_status_in;
  wire stop_amp = stop_release_in && osc_amp_high_range_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      clkgen_pkg::ST_RUN: begin
        if (amp_rise && on_hs_clk) begin
          state_d = ext_mode ? clkgen_pkg::ST_EXT : clkgen_pkg::ST_TIME; // R2 R3
        end else if (stop_amp) begin
          if (!on_hs_clk) begin
            state_d = clkgen_pkg::ST_TIME; // R4
          end else begin
            state_d = ext_mode ? clkgen_pkg::ST_EXT : clkgen_pkg::ST_OST; // R4
          end
        end
      end
      clkgen_pkg::ST_TIME: begin
        if (!time_tif.busy) begin
          state_d = clkgen_pkg::ST_RUN;
        end
      end
      clkgen_pkg::ST_EXT: begin
        if (!ext_tif.busy) begin
          state_d = clkgen_pkg::ST_RUN;
        end
      end
      clkgen_pkg::ST_OST: begin
        if (ost_done_in) begin
          state_d = clkgen_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = clkgen_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= clkgen_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  wire in_run = (state_q == clkgen_pkg::ST_RUN);
  assign time_tif.start = in_run && (state_d == clkgen_pkg::ST_TIME); // R2
  assign time_tif.tick = 1'b1;
  assign time_tif.load = clkgen_pkg::STALL_LOAD;
  assign ext_tif.start = in_run && (state_d == clkgen_pkg::ST_EXT); // R3
  assign ext_tif.tick = ext_rise;
  assign ext_tif.load = clkgen_pkg::EXT_STALL_LOAD;

  cycle_timer #(.W(9)) time_timer (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .tif(time_tif)
  );

  cycle_timer #(.W(9)) ext_timer (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .tif(ext_tif)
  );

  logic div_en;
  cpu_clk_div #(.DW(4)) cpu_div (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .div_sel_in(div_sel_q),
    .en_out(div_en)
  );

  assign cpu_clk_en_out = div_en && in_run; // R9 R2
  assign periph_clk_en_out = 1'b1; // R11
  assign cpu_stalled_out = !in_run;
  assign osc_amp_high_range_out = osc_amp_high_range_q;
  assign x1_osc_enable_out = x1_mode && !hs_osc_halt_q; // R20
  assign ext_clk_enable_out = ext_mode && !hs_osc_halt_q; // R20
  assign irc_osc_enable_out = !highspeed_irc_halt_q; // R18
  assign lowspeed_osc_enable_out = !lowspeed_osc_halt_q; // R18
  assign pll_power_out = pll_power_enable_q;
  assign pll_ready_out = pll_ready;
  assign periph_pll_sel_out = pll_active_status_q; // R17

  // checking helpers
  logic [9:0] stall_len_q;
  logic [8:0] ext_seen_q;
  logic [8:0] pll_on_cnt_q;
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stall_len_q <= 10'h000;
      ext_seen_q <= 9'h000;
      pll_on_cnt_q <= 9'h000;
    end else begin
      stall_len_q <= (state_q == clkgen_pkg::ST_TIME) ? stall_len_q + 10'h001 : 10'h000;
      if (state_q != clkgen_pkg::ST_EXT) begin
        ext_seen_q <= 9'h000;
      end else if (ext_rise && ext_tif.busy) begin
        ext_seen_q <= ext_seen_q + 9'h001;
      end
      if (!pll_power_enable_q) begin
        pll_on_cnt_q <= 9'h000;
      end else if (pll_on_cnt_q != 9'h1ff) begin
        pll_on_cnt_q <= pll_on_cnt_q + 9'h001;
      end
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  time_stall_a: assert property ( // R2
    $fell(state_q == clkgen_pkg::ST_TIME) |->
      ($past(stall_len_q) >= clkgen_pkg::STALL_CYC &&
       $past(stall_len_q) <= clkgen_pkg::STALL_MAX_CYC))
    else $error("timed cpu stall length out of range");
  ext_stall_a: assert property ( // R3
    $fell(state_q == clkgen_pkg::ST_EXT) |-> $past(ext_seen_q) == clkgen_pkg::EXT_STALL_CLKS)
    else $error("external clock stall not 160 edges");
  stop_irc_a: assert property ( // R4
    in_run && stop_amp && !on_hs_clk && !amp_rise |=> state_q == clkgen_pkg::ST_TIME)
    else $error("stop release on internal clock did not stall");
  ost_hold_a: assert property ( // R4
    state_q == clkgen_pkg::ST_OST && !ost_done_in |=> state_q == clkgen_pkg::ST_OST)
    else $error("oscillator wait left early");
  stall_gate_a: assert property ( // R2
    !in_run |-> !cpu_clk_en_out)
    else $error("cpu clock ran during stall");
  div_four_a: assert property ( // R9
    cpu_clk_en_out && div_sel_q == 3'h2 && !wr_div |=> !div_en ##1
      (!div_en || div_sel_q != 3'h2) ##1 (!div_en || div_sel_q != 3'h2))
    else $error("divide by four spacing wrong");
  irc_stable_a: assert property ( // R12
    irc_ready_in |=> irc_stable_status_q)
    else $error("stable status not set");
  ro_status_a: assert property ( // R13
    wr_pll && wd[clkgen_pkg::PLL_ACTIVE_BIT] && !pll_active_status_q && !pll_mode_select_q
      |=> !pll_active_status_q)
    else $error("write reached pll mode status");
  pll_wait_a: assert property ( // R14
    $rose(pll_ready) |-> pll_on_cnt_q == clkgen_pkg::PLL_WAIT_CYC)
    else $error("pll settling wait not 10 us");
  mode_on_a: assert property ( // R16
    go_pll |=> pll_active_status_q)
    else $error("pll mode entry late");
  mode_off_a: assert property ( // R16
    $fell(pll_mode_select_q) && pll_active_status_q |-> ##[1:3] !pll_active_status_q)
    else $error("pll mode exit late");
  halt_irc_a: assert property ( // R18
    wr_pll && wd[clkgen_pkg::HS_IRC_HALT_BIT] |=> !irc_osc_enable_out)
    else $error("internal oscillator not halted");
  main_osc_halt_a: assert property ( // R20
    hs_osc_halt_q |-> !x1_osc_enable_out && !ext_clk_enable_out)
    else $error("high-speed oscillator ran while halted");
  clk_status_read_a: assert property ( // R23
    wb_req && !wb_we_in && hit_stat && !ack_q |=>
      wb_dat_out[clkgen_pkg::CLK_STATUS_BIT] == $past(main_clk_source_status_in))
    else $error("main clock status read wrong");

  time_stall_c: cover property (state_q == clkgen_pkg::ST_TIME ##1 in_run);
  ext_stall_c: cover property (state_q == clkgen_pkg::ST_EXT ##1 in_run);
  ost_wait_c: cover property (state_q == clkgen_pkg::ST_OST ##1 in_run);
  pll_mode_c: cover property ($rose(pll_active_status_q));
endmodule : clock_source_divider_pll_control

// >>> testbench/clock_source_divider_pll_control_tb.sv
`timescale 1ns/1ps
module clock_source_divider_pll_control_tb;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic wb_cyc_in = 1'b0;
  logic wb_stb_in = 1'b0;
  logic wb_we_in = 1'b0;
  logic [17:0] wb_adr_in = 18'h0;
  logic [31:0] wb_dat_in = 32'h0;
  logic [3:0] wb_sel_in = 4'h0;
  logic main_clk_source_status_in = 1'b0;
  logic irc_ready_in = 1'b0;
  logic ext_clk_in = 1'b0;
  logic stop_release_in = 1'b0;
  logic ost_done_in = 1'b0;
  logic [31:0] wb_dat_out;
  logic wb_ack_out, cpu_clk_en_out, periph_clk_en_out, cpu_stalled_out;
  logic osc_amp_high_range_out, x1_osc_enable_out, ext_clk_enable_out;
  logic irc_osc_enable_out, lowspeed_osc_enable_out, pll_power_out;
  logic pll_ready_out, periph_pll_sel_out;
  logic [2:0] obs;
  logic [31:0] exp_q[$];
  int n_fail = 0;
  int comparisons = 0;
  int ext_cnt = 0;
  logic ext_run = 1'b0;

  clock_source_divider_pll_control clock_source_divider_pll_control_i (
    .clock_in, .nrst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_in,
    .wb_sel_in, .wb_dat_out, .wb_ack_out, .main_clk_source_status_in, .irc_ready_in,
    .ext_clk_in, .stop_release_in, .ost_done_in, .cpu_clk_en_out, .periph_clk_en_out,
    .cpu_stalled_out, .osc_amp_high_range_out, .x1_osc_enable_out, .ext_clk_enable_out,
    .irc_osc_enable_out, .lowspeed_osc_enable_out, .pll_power_out, .pll_ready_out,
    .periph_pll_sel_out
  );

  assign obs = {pll_ready_out, periph_pll_sel_out, cpu_stalled_out};
  always #12.5 clock_in = ~clock_in;

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    comparisons++;
    if (seen !== expv) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : check

  task automatic complete_run();
    $display("mismatches=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // one classic cycle; released only after the edge that samples ack
  task automatic bus(input logic we, input logic [15:0] idx, input logic [7:0] d);
    int t;
    @(posedge clock_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= {idx, 2'b00};
    wb_dat_in <= {24'h0, d};
    wb_sel_in <= 4'hf;
    t = 0;
    do begin
      @(posedge clock_in);
      t++;
    end while (wb_ack_out !== 1'b1 && t < 50);
    if (t >= 50) n_fail++;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask : bus

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, idx, 8'h00);
  endtask : rd

  // read data is compared against the oldest note when ack appears
  always @(posedge clock_in) begin
    if (wb_ack_out === 1'b1 && wb_cyc_in === 1'b1 && wb_we_in === 1'b0) begin
      check(wb_dat_out, (exp_q.size() > 0) ? exp_q.pop_front() : 32'hffff_ffff);
    end
  end

  // external clock with a random half period of 2 to 4 cycles
  always @(posedge clock_in) begin
    if (ext_run) begin
      if (ext_cnt == 0) begin
        ext_clk_in <= ~ext_clk_in;
        ext_cnt <= $urandom_range(3, 1);
      end else begin
        ext_cnt <= ext_cnt - 1;
      end
    end
  end

  task automatic do_reset();
    @(posedge clock_in);
    nrst_in <= 1'b0;
    repeat (16) @(posedge clock_in);
    nrst_in <= 1'b1;
  endtask : do_reset

  task automatic release_stop();
    @(posedge clock_in);
    stop_release_in <= 1'b1;
    @(posedge clock_in);
    stop_release_in <= 1'b0;
  endtask : release_stop

  task automatic edges_until(input int i, input logic lvl, input int lim, output int t);
    t = 0;
    while (obs[i] !== lvl && t < lim) begin
      @(negedge clock_in);
      t++;
    end
  endtask : edges_until

  // length of one stall and the external rising edges seen during it
  task automatic stall_len(output int n, output int e);
    int t;
    logic prev;
    n = 0;
    e = 0;
    t = 0;
    prev = ext_clk_in;
    while (cpu_stalled_out !== 1'b1 && t < 20) begin
      @(negedge clock_in);
      t++;
    end
    while (cpu_stalled_out === 1'b1 && n < 3000) begin
      check({31'h0, cpu_clk_en_out}, 32'h0);
      if (ext_clk_in === 1'b1 && prev === 1'b0) e++;
      prev = ext_clk_in;
      @(negedge clock_in);
      n++;
    end
  endtask : stall_len

  task automatic div_count(output int c, output int pb);
    c = 0;
    pb = 0;
    repeat (32) begin
      @(negedge clock_in);
      if (cpu_clk_en_out === 1'b1) c++;
      if (periph_clk_en_out !== 1'b1) pb++;
    end
  endtask : div_count

  initial begin
    repeat (60000) @(posedge clock_in);
    n_fail++;
    complete_run();
  end

  initial begin
    int n, e, t, k, cur, c, pb;
    logic [2:0] code;
    void'($urandom(36));
    do_reset();
    rd(clkgen_pkg::OSC_PLL_IDX, 8'h00);
    rd(clkgen_pkg::MAIN_OSC_IDX, 8'h80);
    rd(clkgen_pkg::CPU_DIV_IDX, 8'h01);
    rd(clkgen_pkg::OSC_MODE_IDX, 8'h00);
    rd(16'h1234, 8'h00);
    irc_ready_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    rd(clkgen_pkg::OSC_PLL_IDX, 8'h80);
    cur = 1;
    for (int i = 0; i < 12; i++) begin
      code = (i < 8) ? 3'(i) : 3'($urandom_range(7, 0));
      if (i > 0) wr(clkgen_pkg::CPU_DIV_IDX, {5'h0, code});
      if (i > 0 && code <= 3'h4) cur = int'(code);
      rd(clkgen_pkg::CPU_DIV_IDX, 8'(cur));
      repeat (40) @(posedge clock_in);
      div_count(c, pb);
      check(32'(c), 32'h20 >> cur);
      check(32'(pb), 32'h0);
    end
    main_clk_source_status_in <= 1'b1;
    wr(clkgen_pkg::OSC_PLL_IDX, 8'h03);
    @(negedge clock_in);
    check({30'h0, irc_osc_enable_out, lowspeed_osc_enable_out}, 32'h0);
    wr(clkgen_pkg::OSC_PLL_IDX, 8'ha0);
    rd(clkgen_pkg::OSC_PLL_IDX, 8'h80);
    check({30'h0, irc_osc_enable_out, lowspeed_osc_enable_out}, 32'h3);
    wr(clkgen_pkg::OSC_PLL_IDX, 8'h10);
    edges_until(2, 1'b1, 600, t);
    check(32'(t >= 400 && t <= 402), 32'h1);
    wr(clkgen_pkg::OSC_PLL_IDX, 8'h18);
    edges_until(1, 1'b1, 10, t);
    check(32'(t <= 2), 32'h1);
    rd(clkgen_pkg::OSC_PLL_IDX, 8'hb8);
    wr(clkgen_pkg::OSC_PLL_IDX, 8'h10);
    edges_until(1, 1'b0, 10, t);
    check(32'(t <= 4), 32'h1);
    wr(clkgen_pkg::OSC_PLL_IDX, 8'h00);
    repeat (2) @(negedge clock_in);
    check({29'h0, pll_power_out, pll_ready_out, periph_pll_sel_out}, 32'h0);
    rd(clkgen_pkg::CLK_STATUS_IDX, 8'h02);
    main_clk_source_status_in <= 1'b0;
    rd(clkgen_pkg::CLK_STATUS_IDX, 8'h00);
    wr(clkgen_pkg::OSC_MODE_IDX, 8'h40);
    wr(clkgen_pkg::MAIN_OSC_IDX, 8'h00);
    @(negedge clock_in);
    check({30'h0, x1_osc_enable_out, ext_clk_enable_out}, 32'h2);
    wr(clkgen_pkg::OSC_MODE_IDX, 8'hc0);
    rd(clkgen_pkg::OSC_MODE_IDX, 8'h40);
    main_clk_source_status_in <= 1'b1;
    wr(clkgen_pkg::OSC_MODE_IDX, 8'h41);
    stall_len(n, e);
    check(32'(n >= 200 && n <= 774), 32'h1);
    check({31'h0, osc_amp_high_range_out}, 32'h1);
    wr(clkgen_pkg::OSC_MODE_IDX, 8'h40);
    rd(clkgen_pkg::OSC_MODE_IDX, 8'h41);
    k = $urandom_range(60, 20);
    release_stop();
    fork
      stall_len(n, e);
      begin
        repeat (k) @(posedge clock_in);
        ost_done_in <= 1'b1;
        @(posedge clock_in);
        ost_done_in <= 1'b0;
      end
    join
    check(32'(n >= k - 1 && n <= k + 3), 32'h1);
    main_clk_source_status_in <= 1'b0;
    wr(clkgen_pkg::MAIN_OSC_IDX, 8'h80);
    @(negedge clock_in);
    check({30'h0, x1_osc_enable_out, ext_clk_enable_out}, 32'h0);
    release_stop();
    stall_len(n, e);
    check(32'(n >= 200 && n <= 774), 32'h1);
    wr(clkgen_pkg::OSC_MODE_IDX, 8'hc1);
    wr(clkgen_pkg::MAIN_OSC_IDX, 8'h00);
    @(negedge clock_in);
    check({30'h0, x1_osc_enable_out, ext_clk_enable_out}, 32'h1);
    main_clk_source_status_in <= 1'b1;
    ext_run <= 1'b1;
    release_stop();
    stall_len(n, e);
    check(32'(e >= 159 && e <= 161), 32'h1);
    do_reset();
    rd(clkgen_pkg::CPU_DIV_IDX, 8'h01);
    wr(clkgen_pkg::OSC_MODE_IDX, 8'hc0);
    wr(clkgen_pkg::MAIN_OSC_IDX, 8'h00);
    wr(clkgen_pkg::OSC_MODE_IDX, 8'hc1);
    stall_len(n, e);
    check(32'(e >= 159 && e <= 161), 32'h1);
    repeat (4) @(posedge clock_in);
    complete_run();
  end
endmodule : clock_source_divider_pll_control_tb
